//--- hw/adcsc_consts.vh
// constants for the converter configuration and control block
`ifndef ADCSC_CONSTS_VH
`define ADCSC_CONSTS_VH

// register addresses on the internal register port
`define ADCSC_ADDR_CFG 4'h8
`define ADCSC_ADDR_IEN 4'h9
`define ADCSC_ADDR_STAT 4'hA

// configuration word field positions
`define ADCSC_CFG_START 0
`define ADCSC_CFG_RESET 1
`define ADCSC_CFG_AZ 2
`define ADCSC_CFG_CAL 3
`define ADCSC_CFG_STBY 4
`define ADCSC_CFG_TAGMASK 5
`define ADCSC_CFG_AZEACH 6
`define ADCSC_CFG_SYNCDIR 7
`define ADCSC_CFG_SECT_LO 8
`define ADCSC_CFG_SECT_HI 9
`define ADCSC_CFG_TEST 10
`define ADCSC_CFG_DIAG 11
`define ADCSC_CFG_RESET_VAL 16'h0000
`define ADCSC_IEN_RESET_VAL 16'h0000

// interrupt status flag positions
`define ADCSC_FLG_LIMIT 0
`define ADCSC_FLG_PTR 1
`define ADCSC_FLG_FIFO 2
`define ADCSC_FLG_AZ 3
`define ADCSC_FLG_CAL 4
`define ADCSC_FLG_PAUSE 5
`define ADCSC_FLG_STBY 7

// timing
`define ADCSC_CLK_NS 50
`define ADCSC_RESET_HOLD_CYC 2
`define ADCSC_SHORT_CAL_CYC 76
`define ADCSC_FULL_CAL_CYC 4944
`define ADCSC_SETTLE_US 10000
`define ADCSC_SETTLE_CYC (`ADCSC_SETTLE_US * 1000 / `ADCSC_CLK_NS)

// diagnostic input codes
`define ADCSC_DIAG_NONE 3'h0
`define ADCSC_DIAG_REF 3'h1

`endif

//--- hw/adcsc_tagger.v
// result word formatter: sign extension or channel tag in the top bits
`timescale 1ns/1ns
module adcsc_tagger (
  input wire i_clk,
  input wire i_rst,
  input wire i_valid,
  input wire [12:0] i_data,
  input wire [2:0] i_ptr,
  input wire i_mask,
  output reg o_valid,
  output reg [15:0] o_word
);

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_word <= 16'h0000;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        if (i_mask) begin
          o_word <= {{3{i_data[12]}}, i_data};
        end else begin
          o_word <= {i_ptr, i_data};
        end
      end
    end
  end

endmodule

//--- hw/adcsc_config.v
// global configuration, calibration, standby and interrupt control
`timescale 1ns/1ns
`include "adcsc_consts.vh"

module adcsc_config #(
  parameter FULL_CAL_CYC = `ADCSC_FULL_CAL_CYC,
  parameter SETTLE_CYC = `ADCSC_SETTLE_CYC,
  parameter CAL_W = 13,
  parameter SETTLE_W = 18
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [3:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  output reg [15:0] o_reg_rdata,
  input wire i_instr_busy,
  input wire i_instr_done,
  input wire [2:0] i_next_ptr,
  input wire i_conv_busy,
  input wire i_conv_valid,
  input wire [12:0] i_conv_data,
  input wire [4:0] i_fifo_count,
  input wire i_evt_limit,
  input wire i_evt_fifo,
  input wire i_evt_pause,
  input wire [2:0] i_mux_code,
  input wire i_sync_pin,
  output reg o_sync_pin,
  output reg o_sync_oe_n,
  output reg o_conv_trig,
  output reg o_seq_run,
  output reg [2:0] o_instr_ptr,
  output reg o_cal_short,
  output reg o_cal_full,
  output reg o_az_each,
  output reg o_standby,
  output reg o_fifo_clear,
  output wire o_fifo_wr,
  output wire [15:0] o_fifo_word,
  output reg [1:0] o_ram_section,
  output reg o_test_mode,
  output reg o_diag_mode,
  output reg o_ref_connect,
  output reg o_mux_none,
  output reg o_int_n
);

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RUN = 5'h02;
  localparam [4:0] S_DRAIN = 5'h04;
  localparam [4:0] S_CAL = 5'h08;
  localparam [4:0] S_STBY = 5'h10;
  localparam [31:0] SHORT_M1 = `ADCSC_SHORT_CAL_CYC - 1;
  localparam [31:0] FULL_M1 = FULL_CAL_CYC - 1;
  localparam [31:0] SETTLE_M1 = SETTLE_CYC - 1;
  localparam [31:0] RST_M1 = `ADCSC_RESET_HOLD_CYC - 1;
  localparam [CAL_W-1:0] SHORT_LOAD = SHORT_M1[CAL_W-1:0];
  localparam [CAL_W-1:0] FULL_LOAD = FULL_M1[CAL_W-1:0];
  localparam [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_M1[SETTLE_W-1:0];
  localparam [1:0] RST_LOAD = RST_M1[1:0];

  function hit;
    input [3:0] addr;
    input [3:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  reg [4:0] state;
  reg [4:0] next_state;
  reg [15:0] cfg;
  reg [15:0] ien;
  reg [7:0] flags;
  reg [7:0] next_flags;
  reg [2:0] ptr;
  reg rst_field;
  reg [1:0] rst_cnt;
  reg cal_short;
  reg cal_full;
  reg cal_kind_full;
  reg [CAL_W-1:0] cal_cnt;
  reg resume;
  reg stop_req;
  reg settle_act;
  reg [SETTLE_W-1:0] settle_cnt;
  reg sync_ff1;
  reg sync_ff2;
  reg sync_prev;

  wire cfg_wr = i_reg_wr & hit(i_reg_addr, `ADCSC_ADDR_CFG);
  wire ien_wr = i_reg_wr & hit(i_reg_addr, `ADCSC_ADDR_IEN);
  wire stat_rd = i_reg_rd & hit(i_reg_addr, `ADCSC_ADDR_STAT);
  wire wr_start = cfg_wr & i_reg_wdata[`ADCSC_CFG_START];
  wire wr_stop = cfg_wr & ~i_reg_wdata[`ADCSC_CFG_START];
  wire standby = cfg[`ADCSC_CFG_STBY];
  wire stby_exit = cfg_wr & standby & ~i_reg_wdata[`ADCSC_CFG_STBY];
  wire stby_enter = cfg_wr & i_reg_wdata[`ADCSC_CFG_STBY];
  wire cal_done = state[3] & (cal_cnt == {CAL_W{1'b0}});
  wire cal_any = cal_short | cal_full;
  // a finished full run must hand over to a pending short one, not rerun itself
  wire pick_full = cal_full & ~(cal_done & cal_kind_full);
  wire running = state[1] | state[2] | (state[3] & resume);
  wire cal_load = (next_state == S_CAL) & (~state[3] | cal_done);
  wire settle_done = settle_act & (settle_cnt == {SETTLE_W{1'b0}});
  wire [15:0] cfg_view = {4'h0, cfg[11:4], cal_full, cal_short, rst_field, running};

  // sequencer control; standby wins, then system reset
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (cal_any) begin
          next_state = S_CAL;
        end else if (wr_start) begin
          next_state = S_RUN;
        end
      end
      S_RUN: begin
        if (i_evt_pause) begin
          next_state = S_IDLE;
        end else if (wr_stop | cal_any) begin
          next_state = S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (~i_instr_busy) begin
          if (cal_any) begin
            next_state = S_CAL;
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      S_CAL: begin
        if (cal_done) begin
          if ((cal_kind_full & cal_short) | (~cal_kind_full & cal_full)) begin
            next_state = S_CAL;
          end else if (resume) begin
            next_state = S_RUN;
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      S_STBY: begin
        next_state = S_STBY;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (standby & ~stby_exit) begin
      next_state = S_STBY;
    end else if (rst_field | (cfg_wr & i_reg_wdata[`ADCSC_CFG_RESET])) begin
      next_state = S_IDLE;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // reset field: power-up reset also passes through it
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_field <= 1'b1;
      rst_cnt <= RST_LOAD;
    end else if (stby_enter | (standby & ~stby_exit)) begin
      rst_field <= 1'b1;
      rst_cnt <= RST_LOAD;
    end else if (stby_exit | (cfg_wr & i_reg_wdata[`ADCSC_CFG_RESET])) begin
      rst_field <= 1'b1;
      rst_cnt <= RST_LOAD;
    end else if (rst_cnt != 2'h0) begin
      rst_cnt <= rst_cnt - 2'h1;
    end else begin
      rst_field <= 1'b0;
    end
  end

  // stored configuration and enables
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg <= `ADCSC_CFG_RESET_VAL;
      ien <= `ADCSC_IEN_RESET_VAL;
    end else begin
      if (cfg_wr) begin
        cfg <= {4'h0, i_reg_wdata[11:0]};
      end
      if (ien_wr) begin
        ien <= i_reg_wdata;
      end
    end
  end

  // calibration requests, deferred while an instruction is in flight
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cal_short <= 1'b0;
      cal_full <= 1'b0;
      cal_kind_full <= 1'b0;
      cal_cnt <= {CAL_W{1'b0}};
      resume <= 1'b0;
      stop_req <= 1'b0;
    end else if (rst_field | standby) begin
      cal_short <= 1'b0;
      cal_full <= 1'b0;
      resume <= 1'b0;
      stop_req <= 1'b0;
    end else begin
      if (cfg_wr & i_reg_wdata[`ADCSC_CFG_AZ]) begin
        cal_short <= 1'b1;
      end else if (cal_done & ~cal_kind_full) begin
        cal_short <= 1'b0;
      end
      if (cfg_wr & i_reg_wdata[`ADCSC_CFG_CAL]) begin
        cal_full <= 1'b1;
      end else if (cal_done & cal_kind_full) begin
        cal_full <= 1'b0;
      end
      if (cal_load) begin
        cal_kind_full <= pick_full;
        cal_cnt <= pick_full ? FULL_LOAD : SHORT_LOAD;
      end else if (state[3] & ~cal_done) begin
        cal_cnt <= cal_cnt - {{(CAL_W-1){1'b0}}, 1'b1};
      end
      if (state[2] & (next_state == S_CAL)) begin
        resume <= ~stop_req & ~wr_stop;
      end else if (state[3] & cfg_wr) begin
        resume <= i_reg_wdata[`ADCSC_CFG_START];
      end else if (~state[3]) begin
        resume <= 1'b0;
      end
      if ((state[1] | state[2]) & wr_stop) begin
        stop_req <= 1'b1;
      end else if (wr_start | state[0]) begin
        stop_req <= 1'b0;
      end
    end
  end

  // instruction pointer, held across stop and restart
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr <= 3'h0;
    end else if (rst_field) begin
      ptr <= 3'h0;
    end else if (i_instr_done) begin
      ptr <= i_next_ptr;
    end
  end

  // settling delay after standby; counter is long so simulation may shorten it
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      settle_act <= 1'b0;
      settle_cnt <= {SETTLE_W{1'b0}};
    end else if (stby_exit) begin
      settle_act <= 1'b1;
      settle_cnt <= SETTLE_LOAD;
    end else if (settle_done | standby) begin
      settle_act <= 1'b0;
    end else if (settle_act) begin
      settle_cnt <= settle_cnt - {{(SETTLE_W-1){1'b0}}, 1'b1};
    end
  end

  // status flags: an event in the read cycle survives the read
  always @* begin
    next_flags = flags & ~{8{stat_rd}};
    next_flags[`ADCSC_FLG_LIMIT] = next_flags[`ADCSC_FLG_LIMIT] | i_evt_limit;
    next_flags[`ADCSC_FLG_PTR] = next_flags[`ADCSC_FLG_PTR] | (i_instr_done & (i_next_ptr == ien[10:8]));
    next_flags[`ADCSC_FLG_FIFO] = next_flags[`ADCSC_FLG_FIFO] | i_evt_fifo;
    next_flags[`ADCSC_FLG_AZ] = next_flags[`ADCSC_FLG_AZ] | (cal_done & ~cal_kind_full);
    next_flags[`ADCSC_FLG_CAL] = next_flags[`ADCSC_FLG_CAL] | (cal_done & cal_kind_full);
    next_flags[`ADCSC_FLG_PAUSE] = next_flags[`ADCSC_FLG_PAUSE] | (state[1] & i_evt_pause);
    next_flags[6] = 1'b0;
    next_flags[`ADCSC_FLG_STBY] = next_flags[`ADCSC_FLG_STBY] | settle_done;
    if (rst_field) begin
      next_flags = 8'h00;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flags <= 8'h00;
      o_int_n <= 1'b1;
    end else begin
      flags <= next_flags;
      o_int_n <= ~|(next_flags & ien[7:0]);
    end
  end

  // trigger pin: two flops before the edge detector
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_ff1 <= 1'b0;
      sync_ff2 <= 1'b0;
      sync_prev <= 1'b0;
      o_conv_trig <= 1'b0;
      o_sync_pin <= 1'b0;
      o_sync_oe_n <= 1'b1;
    end else begin
      sync_ff1 <= i_sync_pin;
      sync_ff2 <= sync_ff1;
      sync_prev <= sync_ff2;
      o_conv_trig <= ~cfg[`ADCSC_CFG_SYNCDIR] & sync_ff2 & ~sync_prev;
      o_sync_pin <= cfg[`ADCSC_CFG_SYNCDIR] & i_conv_busy;
      o_sync_oe_n <= ~cfg[`ADCSC_CFG_SYNCDIR];
    end
  end

  // control outputs toward sequencer, analog and multiplexer
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_seq_run <= 1'b0;
      o_instr_ptr <= 3'h0;
      o_cal_short <= 1'b0;
      o_cal_full <= 1'b0;
      o_az_each <= 1'b0;
      o_standby <= 1'b0;
      o_fifo_clear <= 1'b1;
      o_ram_section <= 2'h0;
      o_test_mode <= 1'b0;
      o_diag_mode <= 1'b0;
      o_ref_connect <= 1'b0;
      o_mux_none <= 1'b0;
    end else begin
      o_seq_run <= (next_state == S_RUN);
      o_instr_ptr <= ptr;
      o_cal_short <= (next_state == S_CAL) & ~(cal_load ? pick_full : cal_kind_full);
      o_cal_full <= (next_state == S_CAL) & (cal_load ? pick_full : cal_kind_full);
      o_az_each <= cfg[`ADCSC_CFG_AZEACH];
      o_standby <= standby;
      o_fifo_clear <= rst_field;
      o_ram_section <= cfg[`ADCSC_CFG_SECT_HI:`ADCSC_CFG_SECT_LO];
      o_test_mode <= cfg[`ADCSC_CFG_TEST];
      o_diag_mode <= cfg[`ADCSC_CFG_DIAG];
      o_ref_connect <= cfg[`ADCSC_CFG_DIAG] & (i_mux_code == `ADCSC_DIAG_REF);
      o_mux_none <= cfg[`ADCSC_CFG_DIAG] & (i_mux_code == `ADCSC_DIAG_NONE);
    end
  end

  // register read port; unmapped addresses read zero
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      if (hit(i_reg_addr, `ADCSC_ADDR_CFG)) begin
        o_reg_rdata <= cfg_view;
      end else if (hit(i_reg_addr, `ADCSC_ADDR_IEN)) begin
        o_reg_rdata <= ien;
      end else if (stat_rd) begin
        o_reg_rdata <= {i_fifo_count, ptr, flags};
      end else begin
        o_reg_rdata <= 16'h0000;
      end
    end
  end

  adcsc_tagger u_tagger (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(i_conv_valid),
    .i_data(i_conv_data),
    .i_ptr(ptr),
    .i_mask(cfg[`ADCSC_CFG_TAGMASK]),
    .o_valid(o_fifo_wr),
    .o_word(o_fifo_word)
  );

endmodule

//--- dv/adcsc_monitor.sv
// assertion checker watching the configuration block ports
`timescale 1ns/1ns
module adcsc_monitor #(
  parameter FULL_CAL_CYC = 20
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_reg_wr,
  input wire i_conv_busy,
  input wire i_conv_valid,
  input wire [12:0] i_conv_data,
  input wire [2:0] i_mux_code,
  input wire o_sync_pin,
  input wire o_sync_oe_n,
  input wire o_conv_trig,
  input wire o_seq_run,
  input wire [2:0] o_instr_ptr,
  input wire o_cal_short,
  input wire o_cal_full,
  input wire o_standby,
  input wire o_fifo_clear,
  input wire o_fifo_wr,
  input wire [15:0] o_fifo_word,
  input wire o_ref_connect,
  input wire o_mux_none
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  reg [15:0] n_az;
  reg [15:0] n_cal;
  reg [2:0] n_clr;
  // run lengths of the calibration levels and of the buffer clear outside standby
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      n_az <= 16'h0000;
      n_cal <= 16'h0000;
      n_clr <= 3'h0;
    end else begin
      n_az <= o_cal_short ? n_az + 16'h0001 : 16'h0000;
      n_cal <= o_cal_full ? n_cal + 16'h0001 : 16'h0000;
      n_clr <= (o_fifo_clear && !o_standby && n_clr != 3'h7) ? n_clr + 3'h1 : 3'h0;
    end
  end
  sequence s_stopped;
    !o_seq_run && o_instr_ptr == 3'h0;
  endsequence
  property p_sync_out;
    (!o_sync_oe_n && i_conv_busy && !$past(i_reg_wr)) |=> o_sync_pin;
  endproperty
  a_sync_out: assert property (p_sync_out) else $error("trigger output low during conversion");
  property p_trig_in;
    o_conv_trig |-> o_sync_oe_n;
  endproperty
  a_trig_in: assert property (p_trig_in) else $error("trigger pulse while pin is output");
  property p_tag;
    i_conv_valid |=> (o_fifo_wr && o_fifo_word[12:0] == $past(i_conv_data));
  endproperty
  a_tag: assert property (p_tag) else $error("result word not written or data changed");
  property p_az_len;
    $fell(o_cal_short) |-> (n_az >= 16'h004B && n_az <= 16'h004D);
  endproperty
  a_az_len: assert property (p_az_len) else $error("short calibration length wrong");
  property p_cal_len;
    $fell(o_cal_full) |-> (n_cal >= FULL_CAL_CYC - 1 && n_cal <= FULL_CAL_CYC + 1);
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("full calibration length wrong");
  property p_ref;
    o_ref_connect |-> $past(i_mux_code) == 3'h1;
  endproperty
  a_ref: assert property (p_ref) else $error("references connected for wrong code");
  property p_none;
    o_mux_none |-> $past(i_mux_code) == 3'h0;
  endproperty
  a_none: assert property (p_none) else $error("inputs opened for wrong code");
  property p_clr;
    n_clr < 3'h6;
  endproperty
  a_clr: assert property (p_clr) else $error("reset field stayed high outside standby");
  property p_rst;
    $rose(o_fifo_clear) |-> ##1 s_stopped;
  endproperty
  a_rst: assert property (p_rst) else $error("reset did not stop sequencer");
  property p_stby;
    $rose(o_standby) |-> ##2 !o_seq_run;
  endproperty
  a_stby: assert property (p_stby) else $error("sequencer ran in standby");
endmodule

//--- dv/adcsc_seq_model.sv
// partner model: instruction engine answering the run request
`timescale 1ns/1ns
module adcsc_seq_model (
  input wire i_clk,
  input wire i_rst,
  input wire i_run,
  input wire i_clr,
  output reg o_busy,
  output reg o_done,
  output reg [2:0] o_next_ptr,
  output reg o_conv_valid,
  output reg [12:0] o_conv_data,
  output reg [2:0] o_idx
);
  reg [1:0] step;
  always @(negedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_next_ptr <= 3'h0;
      o_conv_valid <= 1'b0;
      o_conv_data <= 13'h0000;
      o_idx <= 3'h0;
      step <= 2'h0;
    end else begin
      o_done <= 1'b0;
      o_conv_valid <= 1'b0;
      // lines toggle when not qualified so stale values never pass as data
      o_next_ptr <= ~o_next_ptr;
      o_conv_data <= ~o_conv_data;
      if (i_clr) begin
        o_busy <= 1'b0;
        o_idx <= 3'h0;
      end else if (o_busy) begin
        step <= step + 2'h1;
        if (step == 2'h2) begin
          o_conv_valid <= 1'b1;
          o_conv_data <= {o_idx[0], 12'hABC};
        end
        if (step == 2'h3) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
          o_next_ptr <= o_idx + 3'h1;
          o_idx <= o_idx + 3'h1;
        end
      end else if (i_run && !o_done) begin
        o_busy <= 1'b1;
        step <= 2'h0;
      end
    end
  end
endmodule

//--- dv/adcsc_config_tb_top.sv
// testbench for the configuration and control block
`timescale 1ns/1ns
module adcsc_config_tb_top;
  reg i_clk, i_rst, i_reg_wr, i_reg_rd, i_evt_limit, i_evt_fifo, i_evt_pause, sync_drv, ovl;
  reg [3:0] i_reg_addr;
  reg [15:0] i_reg_wdata, v, last_word;
  reg [4:0] i_fifo_count;
  reg [2:0] i_mux_code, kk;
  reg [7:0] trig_n = 8'h00;
  reg [7:0] t0;
  integer num_errors, tests_run, i, n, cyc;
  wire [15:0] o_reg_rdata, o_fifo_word;
  wire [12:0] i_conv_data;
  wire [2:0] i_next_ptr, o_instr_ptr, m_idx;
  wire [1:0] o_ram_section;
  wire i_instr_busy, i_instr_done, i_conv_valid, o_sync_pin, o_sync_oe_n, o_conv_trig, o_seq_run;
  wire o_cal_short, o_cal_full, o_az_each, o_standby, o_fifo_clear, o_fifo_wr;
  wire o_test_mode, o_diag_mode, o_ref_connect, o_mux_none, o_int_n;
  wire i_conv_busy = i_instr_busy;
  // pin level from both drivers: block when its enable is low, bench otherwise
  wire i_sync_pin = o_sync_oe_n ? sync_drv : o_sync_pin;
  adcsc_config #(.FULL_CAL_CYC(20), .SETTLE_CYC(10)) DUT (.i_clk, .i_rst, .i_reg_wr, .i_reg_rd,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_instr_busy, .i_instr_done, .i_next_ptr, .i_conv_busy,
    .i_conv_valid, .i_conv_data, .i_fifo_count, .i_evt_limit, .i_evt_fifo, .i_evt_pause, .i_mux_code,
    .i_sync_pin, .o_sync_pin, .o_sync_oe_n, .o_conv_trig, .o_seq_run, .o_instr_ptr, .o_cal_short,
    .o_cal_full, .o_az_each, .o_standby, .o_fifo_clear, .o_fifo_wr, .o_fifo_word, .o_ram_section,
    .o_test_mode, .o_diag_mode, .o_ref_connect, .o_mux_none, .o_int_n);
  adcsc_seq_model u_seq (.i_clk(i_clk), .i_rst(i_rst), .i_run(o_seq_run), .i_clr(o_fifo_clear),
    .o_busy(i_instr_busy), .o_done(i_instr_done), .o_next_ptr(i_next_ptr), .o_conv_valid(i_conv_valid),
    .o_conv_data(i_conv_data), .o_idx(m_idx));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_conv_trig === 1'b1) trig_n <= trig_n + 8'h01;
    if (o_fifo_wr === 1'b1) last_word <= o_fifo_word;
    if (o_cal_full === 1'b1 && i_instr_busy === 1'b1) ovl <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      test_done;
    end
  end
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(negedge i_clk);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      @(negedge i_clk);
      i_reg_wr = 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [15:0] d);
    begin
      @(negedge i_clk);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      @(negedge i_clk);
      i_reg_rd = 1'b0;
      @(negedge i_clk);
      d = o_reg_rdata;
    end
  endtask
  task chk(input string nm, input [15:0] s, input [15:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        num_errors = num_errors + 1;
        $display("Error %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task pause(input integer c);
    repeat (c) @(negedge i_clk);
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    {i_rst, i_reg_wr, i_reg_rd, i_evt_limit, i_evt_fifo, i_evt_pause, sync_drv, ovl} = 8'h80;
    {i_reg_addr, i_reg_wdata, i_mux_code, last_word} = 39'h0;
    i_fifo_count = 5'h05;
    {num_errors, tests_run, cyc} = 0;
    pause(6);
    i_rst = 1'b0;
    v = 16'h0002;
    for (n = 0; n < 20 && v[1] !== 1'b0; n = n + 1) rd(4'h8, v);
    chk("cfg_reset", v, 16'h0000);
    rd(4'hA, v);
    chk("stat_reset", v, 16'h2800);
    wr(4'h3, 16'hFFFF);
    rd(4'h3, v);
    chk("unmapped", v, 16'h0000);
    $display("test reset done");
    for (i = 0; i < 3; i = i + 1) begin
      wr(4'h8, 16'hF8E0 | (i << 8));
      rd(4'h8, v);
      chk("cfg_rw", v, 16'h08E0 | (i << 8));
      chk("ram_section", o_ram_section, i[15:0]);
    end
    chk("pin_oe", o_sync_oe_n, 1'b0);
    chk("az_each", o_az_each, 1'b1);
    chk("test_mode", o_test_mode, 1'b0);
    chk("diag", o_diag_mode, 1'b1);
    i_mux_code = 3'h1;
    pause(2);
    chk("ref_connect", o_ref_connect, 1'b1);
    i_mux_code = 3'h0;
    pause(2);
    chk("mux_none", o_mux_none, 1'b1);
    wr(4'h8, 16'h0000);
    pause(2);
    chk("pin_in", o_sync_oe_n, 1'b1);
    t0 = trig_n;
    sync_drv = 1'b1;
    pause(6);
    chk("trigger", trig_n - t0, 16'h0001);
    sync_drv = 1'b0;
    $display("test fields done");
    wr(4'h9, 16'h0098);
    rd(4'hA, v);
    wr(4'h8, 16'h0001);
    rd(4'h8, v);
    chk("running", v[0], 1'b1);
    pause(20);
    for (n = 0; n < 20 && i_instr_busy !== 1'b1; n = n + 1) pause(1);
    wr(4'h8, 16'h0000);
    pause(10);
    rd(4'h8, v);
    chk("stopped", v[0], 1'b0);
    rd(4'hA, v);
    chk("ptr_next", v[10:8], m_idx);
    kk = m_idx - 3'h1;
    chk("tag_ptr", last_word, {kk, kk[0], 12'hABC});
    $display("test sequencer done");
    wr(4'h8, 16'h00A1);
    for (n = 0; n < 20 && i_instr_busy !== 1'b1; n = n + 1) pause(1);
    chk("pin_out", o_sync_pin, 1'b1);
    wr(4'h8, 16'h00A9);
    for (n = 0; n < 20 && o_cal_full !== 1'b1; n = n + 1) pause(1);
    for (n = 0; n < 100 && o_cal_full !== 1'b0; n = n + 1) pause(1);
    chk("cal_defer", ovl, 1'b0);
    pause(10);
    chk("resume", o_seq_run, 1'b1);
    chk("int_full", o_int_n, 1'b0);
    wr(4'h8, 16'h0020);
    pause(10);
    kk = m_idx - 3'h1;
    chk("tag_sign", last_word, {{3{kk[0]}}, kk[0], 12'hABC});
    rd(4'hA, v);
    chk("flag_full", v & 16'h0018, 16'h0010);
    chk("ptr_resume", v[10:8], m_idx);
    pause(1);
    chk("int_clear", o_int_n, 1'b1);
    wr(4'h8, 16'h0004);
    rd(4'h8, v);
    chk("az_pending", v[2], 1'b1);
    for (n = 0; n < 100 && o_cal_short !== 1'b0; n = n + 1) pause(1);
    rd(4'h8, v);
    chk("az_clear", v[2], 1'b0);
    chk("int_az", o_int_n, 1'b0);
    rd(4'hA, v);
    chk("flag_az", v & 16'h0018, 16'h0008);
    $display("test calibration done");
    wr(4'h8, 16'h0001);
    pause(8);
    wr(4'h8, 16'h0003);
    v = 16'h0002;
    for (n = 0; n < 10 && v[1] !== 1'b0; n = n + 1) rd(4'h8, v);
    chk("reset_stop", v, 16'h0000);
    rd(4'hA, v);
    chk("reset_stat", v[10:0], 11'h000);
    wr(4'h8, 16'h0010);
    rd(4'h8, v);
    chk("standby", o_standby, 1'b1);
    chk("stby_hold", v, 16'h0012);
    wr(4'h8, 16'h0000);
    for (n = 0; n < 100 && o_int_n !== 1'b0; n = n + 1) pause(1);
    rd(4'hA, v);
    chk("stby_done", v[7], 1'b1);
    chk("stby_ptr", v[10:8], 3'h0);
    wr(4'h8, 16'h0001);
    rd(4'h8, v);
    chk("restart", v[0], 1'b1);
    $display("test reset and standby done");
    test_done;
  end
endmodule
bind adcsc_config adcsc_monitor #(.FULL_CAL_CYC(FULL_CAL_CYC)) u_mon (.i_clk, .i_rst, .i_reg_wr, .i_conv_busy,
  .i_conv_valid, .i_conv_data, .i_mux_code, .o_sync_pin, .o_sync_oe_n, .o_conv_trig, .o_seq_run, .o_instr_ptr,
  .o_cal_short, .o_cal_full, .o_standby, .o_fifo_clear, .o_fifo_wr, .o_fifo_word, .o_ref_connect, .o_mux_none);
